// ---- sifr_framer.sv ----
`timescale 1ns/1ps
module sifr_framer (
	input wire logic clk, // 40 MHz clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic hsel, // ahb slave select
	input wire logic [7:0] haddr, // ahb byte address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size, word only
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb bus ready
	output logic hreadyout, // ahb slave ready
	output logic [31:0] hrdata, // ahb read data
	output logic hresp, // ahb response, always okay
	input wire sifr_pkg::sifr_sample_s sample, // received remote sample
	input wire logic sample_valid, // sample offered
	output logic sample_ready, // framer can take a sample
	output sifr_pkg::sifr_byte_s out_byte, // serial byte and end-of-frame
	output logic out_valid, // byte offered to the port
	input wire logic out_ready // port takes the byte
);
	import sifr_pkg::*;

	function automatic sifr_build_s build_frame(input sifr_sample_s s, input logic expl,
		input logic [31:0] eps, input logic [15:0] prof);
		sifr_build_s r;
		logic [5:0] p;
		logic [15:0] dm;
		logic [7:0] am;
		logic [7:0] sum;
		logic [5:0] len;
		r = '0;
		dm = {1'b0, s.dmask[14:0]};
		am = s.amask & AMASK_VALID;
		r.frame[OFF_DELIM] = START_DELIM;
		r.frame[OFF_TYPE] = expl ? TYPE_EXPLICIT : TYPE_IO_SAMPLE;
		for (int i = 0; i < 8; i++) begin
			r.frame[OFF_ADDR + 6'(i)] = s.src_addr[8*(7-i) +: 8];
		end
		r.frame[OFF_RSVD] = RESERVED_FILL[15:8];
		r.frame[OFF_RSVD + 6'd1] = RESERVED_FILL[7:0];
		if (expl) begin
			r.frame[OFF_SRC_EP] = eps[7:0];
			r.frame[OFF_DST_EP] = eps[15:8];
			r.frame[OFF_CLUSTER] = eps[31:24];
			r.frame[OFF_CLUSTER + 6'd1] = eps[23:16];
			r.frame[OFF_PROFILE] = prof[15:8];
			r.frame[OFF_PROFILE + 6'd1] = prof[7:0];
			r.frame[OFF_EXPL_OPTS] = s.rx_opts & 8'h03;
			p = OFF_EXPL_OPTS + 6'd1;
		end else begin
			r.frame[OFF_OPTS] = s.rx_opts & 8'h03;
			p = OFF_NSAMP;
		end
		r.frame[p] = s.num_samples;
		r.frame[p + 6'd1] = dm[15:8];
		r.frame[p + 6'd2] = dm[7:0];
		r.frame[p + 6'd3] = am;
		p = p + 6'd4;
		if (dm != 16'h0000) begin
			r.frame[p] = s.dsamples[15:8] & dm[15:8];
			r.frame[p + 6'd1] = s.dsamples[7:0] & dm[7:0];
			p = p + 6'd2;
		end
		for (int i = 0; i < 4; i++) begin
			if (am[i]) begin
				r.frame[p] = s.analog[i][15:8];
				r.frame[p + 6'd1] = s.analog[i][7:0];
				p = p + 6'd2;
			end
		end
		if (am[7]) begin
			r.frame[p] = s.supply[15:8];
			r.frame[p + 6'd1] = s.supply[7:0];
			p = p + 6'd2;
		end
		len = p - OFF_TYPE;
		r.frame[OFF_LEN] = 8'h00;
		r.frame[OFF_LEN + 6'd1] = {2'b00, len};
		sum = 8'h00;
		for (int i = 3; i < FRAME_MAX; i++) begin
			if (6'(i) < p) begin
				sum = sum + r.frame[i];
			end
		end
		r.frame[p] = CHECKSUM_BASE - sum;
		r.count = p + 6'd1;
		return r;
	endfunction

	function automatic logic [31:0] rd_word(input logic [7:0] a, input logic [7:0] esc,
		input logic [7:0] oopt, input logic [31:0] eps, input logic [15:0] prof,
		input logic [7:0] sent, input logic [7:0] drop, input logic busy);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			REG_CONFIG: w = {16'h0000, oopt, esc};
			REG_ENDPOINTS: w = eps;
			REG_PROFILE: w = {16'h0000, prof};
			REG_STATUS: w = {8'h00, drop, sent, 7'h00, busy};
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	// register file
	logic [7:0] api_escape_setting;
	logic [7:0] api_output_option;
	logic [31:0] endpoints;
	logic [15:0] profile;
	logic [7:0] frames_sent;
	logic [7:0] frames_dropped;

	// bus slave
	sifr_state_e state;
	logic dph_valid;
	logic dph_write;
	logic [7:0] dph_addr;
	logic rd_pending;
	wire bus_take = hsel && htrans[1] && hready;
	wire bus_wr = dph_valid && dph_write;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			dph_valid <= 1'b0;
			dph_write <= 1'b0;
			dph_addr <= 8'h00;
			rd_pending <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else begin
			dph_valid <= bus_take;
			dph_write <= hwrite;
			dph_addr <= {haddr[7:2], 2'b00};
			rd_pending <= bus_take && !hwrite;
			if (bus_take && !hwrite) begin
				hreadyout <= 1'b0;
			end else if (rd_pending) begin
				hreadyout <= 1'b1;
				hrdata <= rd_word(dph_addr, api_escape_setting, api_output_option, endpoints,
					profile, frames_sent, frames_dropped, state == ST_SEND);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			api_escape_setting <= RST_ESCAPE;
			api_output_option <= RST_OUTOPT;
			endpoints <= RST_ENDPOINTS;
			profile <= RST_PROFILE;
		end else if (bus_wr) begin
			case (dph_addr)
				REG_CONFIG: begin
					api_escape_setting <= hwdata[7:0];
					api_output_option <= hwdata[15:8];
				end
				REG_ENDPOINTS: endpoints <= hwdata;
				REG_PROFILE: profile <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	// frame source
	sifr_frame_t frame;
	logic [5:0] count;
	logic [5:0] idx;
	logic buf_in_ready;

	wire api_mode = api_escape_setting != 8'h00;
	wire outopt_std = api_output_option == OUTOPT_STANDARD;
	wire outopt_expl = api_output_option >= OUTOPT_EXPLICIT_MIN;
	wire accept = sample_valid && sample_ready;
	wire emit = api_mode && (outopt_std || outopt_expl);
	wire sifr_build_s built = build_frame(sample, outopt_expl, endpoints, profile);
	wire push = (state == ST_SEND) && buf_in_ready;
	wire push_last = idx == count - 6'd1;
	wire [7:0] push_data = frame[idx];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			frame <= '0;
			count <= 6'd0;
			idx <= 6'd0;
			sample_ready <= 1'b1;
			frames_sent <= 8'h00;
			frames_dropped <= 8'h00;
		end else if (state == ST_IDLE) begin
			if (accept && emit) begin
				state <= ST_SEND;
				frame <= built.frame;
				count <= built.count;
				idx <= 6'd0;
				sample_ready <= 1'b0;
			end else if (accept) begin
				frames_dropped <= frames_dropped + 8'h01;
			end
		end else if (push) begin
			idx <= idx + 6'd1;
			if (push_last) begin
				state <= ST_IDLE;
				sample_ready <= 1'b1;
				frames_sent <= frames_sent + 8'h01;
			end
		end
	end

	// two-entry output buffer, head feeds the port directly
	sifr_byte_s spare;
	logic spare_valid;
	wire pop = out_valid && out_ready;
	wire sifr_byte_s in_byte = '{data: push_data, last: push_last};
	assign buf_in_ready = !spare_valid;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			out_valid <= 1'b0;
			out_byte <= '0;
			spare <= '0;
			spare_valid <= 1'b0;
		end else if (spare_valid) begin
			if (pop) begin
				out_byte <= spare;
				spare_valid <= 1'b0;
			end
		end else if (push) begin
			if (!out_valid || pop) begin
				out_byte <= in_byte;
				out_valid <= 1'b1;
			end else begin
				spare <= in_byte;
				spare_valid <= 1'b1;
			end
		end else if (pop) begin
			out_valid <= 1'b0;
		end
	end

	// checks
	logic [7:0] run_sum;
	always_ff @(posedge clk) begin
		if (!resetn || state == ST_IDLE) begin
			run_sum <= 8'h00;
		end else if (push && idx >= OFF_TYPE && !push_last) begin
			run_sum <= run_sum + push_data;
		end
	end

	sequence s_take_emit;
		accept && emit;
	endsequence

	sequence s_delim_out;
		push && idx == OFF_DELIM && push_data == START_DELIM;
	endsequence

	property p_take_starts_frame;
		@(posedge clk) disable iff (!resetn)
		s_take_emit |=> !sample_ready ##0 (state == ST_SEND) ##0 (idx == OFF_DELIM);
	endproperty
	a_take_starts_frame: assert property (p_take_starts_frame)
		else $error("accepted sample did not start a frame");

	property p_delim_first;
		@(posedge clk) disable iff (!resetn)
		(push && idx == OFF_DELIM) |-> s_delim_out;
	endproperty
	a_delim_first: assert property (p_delim_first)
		else $error("first byte is not the start delimiter");

	property p_no_emit_outside_api;
		@(posedge clk) disable iff (!resetn)
		(accept && !api_mode) |=> (state == ST_IDLE) && sample_ready;
	endproperty
	a_no_emit_outside_api: assert property (p_no_emit_outside_api)
		else $error("frame started outside api mode");

	property p_length_field;
		@(posedge clk) disable iff (!resetn)
		(push && idx == OFF_LEN + 6'd1) |-> push_data == {2'b00, count - LEN_EXCLUDED};
	endproperty
	a_length_field: assert property (p_length_field)
		else $error("length field mismatch");

	property p_type_byte;
		@(posedge clk) disable iff (!resetn)
		(push && idx == OFF_TYPE) |->
			push_data == (outopt_expl ? TYPE_EXPLICIT : TYPE_IO_SAMPLE);
	endproperty
	a_type_byte: assert property (p_type_byte)
		else $error("frame type byte wrong");

	property p_checksum;
		@(posedge clk) disable iff (!resetn)
		(push && push_last) |-> 8'(push_data + run_sum) == CHECKSUM_BASE;
	endproperty
	a_checksum: assert property (p_checksum)
		else $error("checksum does not close the frame");

	property p_opts_byte;
		@(posedge clk) disable iff (!resetn)
		(push && idx == OFF_OPTS && !outopt_expl) |-> push_data[7:2] == 6'h00;
	endproperty
	a_opts_byte: assert property (p_opts_byte)
		else $error("reserved receive option bits set");

	property p_frame_ends;
		@(posedge clk) disable iff (!resetn)
		(push && push_last) |=> sample_ready && state == ST_IDLE;
	endproperty
	a_frame_ends: assert property (p_frame_ends)
		else $error("framer did not return to idle after checksum");

	property p_hold_stalled;
		@(posedge clk) disable iff (!resetn)
		(out_valid && !out_ready) |=> out_valid && $stable(out_byte);
	endproperty
	a_hold_stalled: assert property (p_hold_stalled)
		else $error("stalled output byte changed");

	property p_read_answer;
		@(posedge clk) disable iff (!resetn)
		(bus_take && !hwrite) |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("register read not answered in two cycles");

	// standard frames: dmask at nsamp+1, amask at nsamp+3, digital samples at nsamp+4
	wire take_std = accept && emit && !outopt_expl;

	property p_addr_msb_first;
		@(posedge clk) disable iff (!resetn)
		s_take_emit |=> frame[OFF_ADDR] == $past(sample.src_addr[63:56]);
	endproperty
	a_addr_msb_first: assert property (p_addr_msb_first)
		else $error("sender address not sent msb first");

	property p_sample_count;
		@(posedge clk) disable iff (!resetn)
		take_std |=> frame[OFF_NSAMP] == $past(sample.num_samples);
	endproperty
	a_sample_count: assert property (p_sample_count)
		else $error("sample set count not carried");

	property p_std_masks;
		@(posedge clk) disable iff (!resetn)
		take_std |=>
			!frame[OFF_NSAMP + 6'd1][7] && ((frame[OFF_NSAMP + 6'd3] & ~AMASK_VALID) == 8'h00);
	endproperty
	a_std_masks: assert property (p_std_masks)
		else $error("unused channel mask bits set");

	property p_digital_masked;
		@(posedge clk) disable iff (!resetn)
		(take_std && sample.dmask[14:0] != 15'h0000) |=>
			((frame[OFF_NSAMP + 6'd4] & ~frame[OFF_NSAMP + 6'd1]) == 8'h00) &&
			((frame[OFF_NSAMP + 6'd5] & ~frame[OFF_NSAMP + 6'd2]) == 8'h00);
	endproperty
	a_digital_masked: assert property (p_digital_masked)
		else $error("digital sample set on a line outside the mask");

	property p_no_optional_fields;
		@(posedge clk) disable iff (!resetn)
		(take_std && sample.dmask[14:0] == 15'h0000 &&
			((sample.amask & AMASK_VALID) == 8'h00)) |=> count == OFF_NSAMP + 6'd5;
	endproperty
	a_no_optional_fields: assert property (p_no_optional_fields)
		else $error("empty masks did not give a bare frame");

endmodule

// ---- sifr_pkg.sv ----
package sifr_pkg;

	localparam int FRAME_MAX = 40;
	localparam logic [7:0] START_DELIM = 8'h7e;
	localparam logic [7:0] TYPE_IO_SAMPLE = 8'h92;
	localparam logic [7:0] TYPE_EXPLICIT = 8'h91;
	localparam logic [15:0] RESERVED_FILL = 16'hfffe;
	localparam logic [7:0] CHECKSUM_BASE = 8'hff;
	localparam logic [7:0] AMASK_VALID = 8'h8f;
	localparam logic [7:0] OUTOPT_STANDARD = 8'h00;
	localparam logic [7:0] OUTOPT_EXPLICIT_MIN = 8'h02;

	// frame offsets
	localparam logic [5:0] OFF_DELIM = 6'd0;
	localparam logic [5:0] OFF_LEN = 6'd1;
	localparam logic [5:0] OFF_TYPE = 6'd3;
	localparam logic [5:0] OFF_ADDR = 6'd4;
	localparam logic [5:0] OFF_RSVD = 6'd12;
	localparam logic [5:0] OFF_OPTS = 6'd14;
	localparam logic [5:0] OFF_NSAMP = 6'd15;
	localparam logic [5:0] OFF_SRC_EP = 6'd14;
	localparam logic [5:0] OFF_DST_EP = 6'd15;
	localparam logic [5:0] OFF_CLUSTER = 6'd16;
	localparam logic [5:0] OFF_PROFILE = 6'd18;
	localparam logic [5:0] OFF_EXPL_OPTS = 6'd20;
	localparam logic [5:0] LEN_EXCLUDED = 6'd4;

	// register byte offsets
	localparam logic [7:0] REG_CONFIG = 8'h00;
	localparam logic [7:0] REG_ENDPOINTS = 8'h04;
	localparam logic [7:0] REG_PROFILE = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;

	// reset values
	localparam logic [7:0] RST_ESCAPE = 8'h01;
	localparam logic [7:0] RST_OUTOPT = 8'h00;
	localparam logic [31:0] RST_ENDPOINTS = 32'h0000_0000;
	localparam logic [15:0] RST_PROFILE = 16'h0000;

	typedef logic [FRAME_MAX-1:0][7:0] sifr_frame_t;

	typedef struct packed {
		logic [63:0] src_addr;
		logic [7:0] rx_opts;
		logic [7:0] num_samples;
		logic [15:0] dmask;
		logic [7:0] amask;
		logic [15:0] dsamples;
		logic [3:0][15:0] analog;
		logic [15:0] supply;
	} sifr_sample_s;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} sifr_byte_s;

	typedef struct packed {
		sifr_frame_t frame;
		logic [5:0] count;
	} sifr_build_s;

	typedef enum logic {ST_IDLE, ST_SEND} sifr_state_e;

endpackage

// ---- sifr_host_model.sv ----
`timescale 1ns/1ps
module sifr_host_model (
	input wire logic clk, // 40 MHz clock
	input wire logic resetn, // synchronous reset, active low
	input wire sifr_pkg::sifr_byte_s out_byte, // byte from the framer
	input wire logic out_valid, // byte offered
	input wire logic [1:0] pace, // 0 prompt, 1 slow, 2 stalled
	output logic out_ready, // host takes the byte
	output int bad_frames // frames whose checksum failed
);
	import sifr_pkg::*;
	logic [7:0] sum;
	logic [5:0] idx;
	logic [3:0] tick;
	always_ff @(posedge clk) begin
		tick <= tick + 4'h1;
		if (!resetn) begin
			out_ready <= 1'b0;
			sum <= 8'h00;
			idx <= 6'h00;
			tick <= 4'h0;
			bad_frames <= 0;
		end else begin
			out_ready <= (pace == 2'd0) || (pace == 2'd1 && tick[1:0] == 2'b00);
			if (out_valid && out_ready) begin
				idx <= idx + 6'h1;
				if (idx >= OFF_TYPE)
					sum <= sum + out_byte.data;
				if (out_byte.last) begin
					// frame accepted only if the byte sum closes to 0xff
					if (8'(sum + out_byte.data) != 8'hff)
						bad_frames <= bad_frames + 1;
					sum <= 8'h00;
					idx <= 6'h00;
				end
			end
		end
	end
endmodule

// ---- io_sample_indicator_framer_tb.sv ----
`timescale 1ns/1ps
module io_sample_indicator_framer_tb;
	import sifr_pkg::*;
	logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp, sample_valid, sample_ready;
	logic out_valid, out_ready;
	logic [7:0] haddr, oopt;
	logic [1:0] htrans, pace;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd, eps;
	logic [15:0] lfsr, r, prof;
	sifr_sample_s sample, s;
	sifr_byte_s out_byte;
	int fail_count, cmp_count, bad_frames, m;
	int exp[$];
	int pay[$];
	assign hready = hreadyout;
	sifr_framer DUT (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sample(sample),
		.sample_valid(sample_valid), .sample_ready(sample_ready), .out_byte(out_byte),
		.out_valid(out_valid), .out_ready(out_ready));
	sifr_host_model host (.clk(clk), .resetn(resetn), .out_byte(out_byte),
		.out_valid(out_valid), .pace(pace), .out_ready(out_ready), .bad_frames(bad_frames));
	always #12.5 clk = ~clk;
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	task automatic cmp_b(input string nm, input logic [9:0] e, input logic [9:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_w(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic ahb(input logic [7:0] a, input bit wr, input logic [31:0] wd);
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic pb(input logic [63:0] v, input int n);
		for (int k = n - 1; k >= 0; k--)
			pay.push_back(int'(v[k*8+:8]));
	endtask
	task automatic expect_frame(input sifr_sample_s x, input bit ex);
		logic [15:0] dm;
		int sum;
		dm = x.dmask & 16'h7fff;
		sum = 0;
		pay = {};
		pb(ex ? TYPE_EXPLICIT : TYPE_IO_SAMPLE, 1);
		pb(x.src_addr, 8);
		pb(RESERVED_FILL, 2);
		if (ex)
			pb({eps[7:0], eps[15:8], eps[31:16], prof}, 6);
		pb({x.rx_opts & 8'h03, x.num_samples, dm, x.amask & AMASK_VALID}, 5);
		if (dm != 0)
			pb(x.dsamples & dm, 2);
		for (int c = 0; c < 4; c++)
			if (x.amask[c])
				pb(x.analog[c], 2);
		if (x.amask[7])
			pb(x.supply, 2);
		foreach (pay[k])
			sum += pay[k];
		exp.push_back('h7e);
		exp.push_back(pay.size() >> 8);
		exp.push_back(pay.size() & 'hff);
		foreach (pay[k])
			exp.push_back(pay[k]);
		exp.push_back('h100 | (('hff - sum) & 'hff));
	endtask
	always @(posedge clk)
		if (resetn && out_valid === 1'b1 && out_ready === 1'b1)
			cmp_b("out byte", exp.size() ? exp.pop_front() : 'h200, {out_byte.last, out_byte.data});
	initial begin
		#(25 * 20000);
		fail_count++;
		close_out();
	end
	initial begin
		{clk, resetn, hwrite, htrans, haddr, hwdata, sample_valid, pace} = '0;
		hsel = 1'b1;
		hsize = 3'b010;
		sample = '0;
		lfsr = 16'd50297;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		ahb(REG_CONFIG, 0, 0);
		cmp_w("config reset", 32'h1, rd);
		ahb(8'h10, 1, 32'hffff_ffff);
		ahb(8'h10, 0, 0);
		cmp_w("unmapped", 32'h0, {hrdata[31:1], hresp});
		eps = {rnd(), rnd()};
		prof = rnd();
		ahb(REG_ENDPOINTS, 1, eps);
		ahb(REG_PROFILE, 1, {16'h0, prof});
		ahb(REG_ENDPOINTS, 0, 0);
		cmp_w("endpoints", eps, rd);
		for (int i = 0; i < 16; i++) begin
			m = i % 4;
			r = rnd();
			oopt = m == 2 ? (r[7:0] < 8'h02 ? OUTOPT_EXPLICIT_MIN : r[7:0]) : 8'(m == 1);
			ahb(REG_CONFIG, 1, {16'h0, oopt, 8'(m != 3)});
			s.src_addr = {rnd(), rnd(), rnd(), rnd()};
			s.rx_opts = r[15:8];
			r = rnd();
			s.num_samples = r[7:0];
			s.amask = i % 6 == 4 ? 8'h00 : r[15:8];
			s.dmask = i % 3 == 1 ? 16'h0 : rnd();
			s.dsamples = rnd();
			s.analog = {rnd(), rnd(), rnd(), rnd()};
			s.supply = rnd();
			pace <= i == 4 ? 2'd2 : {1'b0, i[0]};
			if (m == 0 || m == 2)
				expect_frame(s, m == 2);
			sample <= s;
			sample_valid <= 1'b1;
			do @(posedge clk); while (sample_ready !== 1'b1);
			sample_valid <= 1'b0;
			if (i == 4) begin
				repeat (30) @(posedge clk);
				cmp_w("stalled frame held", 32'h1, {sample_ready, out_valid});
				pace <= 2'd1;
			end
			for (int k = 0; k < 600 && (exp.size() != 0 || sample_ready !== 1'b1); k++)
				@(posedge clk);
			repeat (3) @(posedge clk);
		end
		ahb(REG_STATUS, 0, 0);
		cmp_w("status", 32'h0008_0800, rd);
		cmp_w("host checksum failures", 32'h0, bad_frames);
		close_out();
	end
endmodule
